// ### rtl/lsf_defines.svh
// Constants of the link status flag bank: offsets, fields, resets, timing.
// Assumes byte addresses on an 8-bit register port with 16-bit data.
`ifndef LSF_DEFINES_SVH
`define LSF_DEFINES_SVH

// =======================================================
// Register offsets
`define LSF_OFS_P2_STATUS  8'h00
`define LSF_OFS_LINK_ERR   8'h04
`define LSF_OFS_STATION_OK 8'h08
`define LSF_OFS_P2_ERRCODE 8'h0C
`define LSF_OFS_IRQ_STATUS 8'h10
`define LSF_OFS_IRQ_MASK   8'h14
`define LSF_OFS_CTRL       8'h18

// =======================================================
// Field positions
`define LSF_P2_READY_BIT   10
`define LSF_P2_ERROR_BIT   11
`define LSF_LINK_TXERR_BIT 0
`define LSF_CTRL_LINK_EN   0
`define LSF_CTRL_SCAN_EN   1
`define LSF_IRQ_P2_ERR     0
`define LSF_IRQ_LINK_ERR   1
`define LSF_IRQ_STN_DROP   2

// =======================================================
// Reset values
`define LSF_RST_WORD       16'h0000
`define LSF_RST_IRQ        3'h0
`define LSF_RST_CTRL       2'h3

// =======================================================
// Timing
`define LSF_CLK_MHZ        250
`define LSF_SCAN_NS        1000
`define LSF_SCAN_CYCLES    ((`LSF_SCAN_NS * `LSF_CLK_MHZ) / 1000)

`endif

// ### rtl/lsf_pkg.sv
// Types shared by the link status flag bank.
// Assumes nothing beyond a SystemVerilog compiler.
package lsf_pkg;

  typedef logic [15:0] lsf_word_t;

  // One-hot states of the second serial port transfer tracker
  typedef enum logic [1:0] {
    LSF_P2_IDLE = 2'b01,
    LSF_P2_BUSY = 2'b10
  } lsf_p2_e;

endpackage

// ### rtl/lsf_link_status_flags.sv
// Read-only status flag bank for the second serial port and the
// controller-to-controller link, with a small interrupt unit.
// Assumes all inputs are synchronous to clk and come from the scan logic.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_defines.svh"

module lsf_link_status_flags (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [15:0] reg_rdata,
  // Second serial port events
  input  wire logic        p2_instr_start,
  input  wire logic        p2_instr_done,
  input  wire logic        p2_comm_error,
  input  wire logic [15:0] p2_error_code,
  // Link events
  input  wire logic        link_tx_error,
  input  wire logic        link_area_cfg_error,
  // Per-station state
  input  wire logic [15:0] station_running,
  input  wire logic [15:0] station_error,
  input  wire logic [15:0] station_link_mode,
  input  wire logic [15:0] station_comm_ok,
  // Interrupt
  output var  logic        irq
);

  // =======================================================
  // Scan divider
  // One tick a scan period stands in for the controller's scan.
  // Clearing scan enable freezes every scanned flag, so software can
  // take a steady snapshot; port two flags do not wait for the tick.
  localparam int unsigned SCAN_CYC = `LSF_SCAN_CYCLES;
  localparam logic [8:0]  SCAN_MAX = 9'(SCAN_CYC - 1);

  logic [8:0] scan_cnt;
  logic [8:0] next_scan_cnt;
  logic       scan_tick;
  logic       next_scan_tick;
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;

  // Wrap by compare, as the period is not a power of two
  always_comb begin
    next_scan_cnt  = scan_cnt;
    next_scan_tick = 1'b0;
    if (ctrl[`LSF_CTRL_SCAN_EN]) begin
      if (scan_cnt == SCAN_MAX) begin
        next_scan_cnt  = 9'h000;
        next_scan_tick = 1'b1;
      end else begin
        next_scan_cnt = scan_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scan_cnt  <= 9'h000;
      scan_tick <= 1'b0;
    end else begin
      scan_cnt  <= next_scan_cnt;
      scan_tick <= next_scan_tick;
    end
  end

  // =======================================================
  // Second serial port tracker
  lsf_pkg::lsf_p2_e p2_state;
  lsf_pkg::lsf_p2_e next_p2_state;
  logic             p2_err_flag;
  logic             next_p2_err_flag;
  logic [15:0]      p2_err_code;
  logic [15:0]      next_p2_err_code;
  logic             p2_err_event;

  // Errors outside a running transfer are not this port's instructions.
  // A start while busy is dropped as well, so the flag always describes
  // the transfer that is running or ran last.
  // The code is kept across starts so the last cause stays readable.
  assign p2_err_event = (p2_state == lsf_pkg::LSF_P2_BUSY) && p2_comm_error;

  always_comb begin
    next_p2_state    = p2_state;
    next_p2_err_flag = p2_err_flag;
    next_p2_err_code = p2_err_code;
    case (p2_state)
      lsf_pkg::LSF_P2_IDLE: begin
        if (p2_instr_start) begin
          next_p2_state    = lsf_pkg::LSF_P2_BUSY;
          next_p2_err_flag = 1'b0;
        end
      end
      lsf_pkg::LSF_P2_BUSY: begin
        if (p2_instr_done) begin
          next_p2_state = lsf_pkg::LSF_P2_IDLE;
        end
      end
      default: next_p2_state = lsf_pkg::LSF_P2_IDLE;
    endcase
    // An error in the ending cycle still counts
    if (p2_err_event) begin
      next_p2_err_flag = 1'b1;
      next_p2_err_code = p2_error_code;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      p2_state    <= lsf_pkg::LSF_P2_IDLE;
      p2_err_flag <= 1'b0;
      p2_err_code <= `LSF_RST_WORD;
    end else begin
      p2_state    <= next_p2_state;
      p2_err_flag <= next_p2_err_flag;
      p2_err_code <= next_p2_err_code;
    end
  end

  // =======================================================
  // Link error flag, refreshed once a scan
  logic link_err_flag;
  logic next_link_err_flag;
  logic link_err_pend;
  logic next_link_err_pend;
  logic link_en;

  // The flag is rebuilt at each tick: a lasting settings fault keeps it
  // high, while a single transmission error shows for one scan only.
  assign link_en = ctrl[`LSF_CTRL_LINK_EN];

  always_comb begin
    next_link_err_flag = link_err_flag;
    // Short error pulses between ticks are held until the next tick
    next_link_err_pend = link_err_pend | (link_en & link_tx_error);
    if (scan_tick) begin
      next_link_err_flag = link_en & (next_link_err_pend
                           | link_area_cfg_error);
      next_link_err_pend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      link_err_flag <= 1'b0;
      link_err_pend <= 1'b0;
    end else begin
      link_err_flag <= next_link_err_flag;
      link_err_pend <= next_link_err_pend;
    end
  end

  // =======================================================
  // Station assurance flags
  logic [15:0] stn_ok;
  logic [15:0] next_stn_ok;
  logic [15:0] stn_healthy;

  // A station is reported only while every condition holds at the tick;
  // any one of stop, error or leaving link mode drops it.
  assign stn_healthy = {16{link_en}} & station_link_mode & station_running
                       & ~station_error & station_comm_ok;

  generate
    for (genvar i = 0; i < 16; i++) begin : g_stn
      assign next_stn_ok[i] = scan_tick ? stn_healthy[i] : stn_ok[i];
    end
  endgenerate

  // Station flags stand still between ticks, like a scan image
  always_ff @(posedge clk) begin
    if (srst) begin
      stn_ok <= `LSF_RST_WORD;
    end else begin
      stn_ok <= next_stn_ok;
    end
  end

  // =======================================================
  // Status words
  lsf_pkg::lsf_word_t p2_word;
  lsf_pkg::lsf_word_t link_word;

  // Unused bits are tied to zero here, so no write path can reach them
  always_comb begin
    p2_word = `LSF_RST_WORD;
    p2_word[`LSF_P2_READY_BIT] = (p2_state == lsf_pkg::LSF_P2_IDLE);
    p2_word[`LSF_P2_ERROR_BIT] = p2_err_flag;
  end

  always_comb begin
    link_word = `LSF_RST_WORD;
    link_word[`LSF_LINK_TXERR_BIT] = link_err_flag;
  end

  // =======================================================
  // Interrupt unit
  logic [2:0] irq_stat;
  logic [2:0] next_irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_mask;
  logic [2:0] irq_evt;
  logic [2:0] irq_clr;
  logic       next_irq;
  logic       wr_irq_stat;
  logic       wr_irq_mask;
  logic       wr_ctrl;

  // Write decode; the status words have no write path at all
  assign wr_irq_stat = reg_wr && (reg_addr == `LSF_OFS_IRQ_STATUS);
  assign wr_irq_mask = reg_wr && (reg_addr == `LSF_OFS_IRQ_MASK);
  assign wr_ctrl     = reg_wr && (reg_addr == `LSF_OFS_CTRL);

  // Link errors count on the rising flag, not per scan, so a lasting
  // settings fault raises the interrupt once rather than every tick
  always_comb begin
    irq_evt = 3'h0;
    irq_evt[`LSF_IRQ_P2_ERR]   = p2_err_event;
    irq_evt[`LSF_IRQ_LINK_ERR] = next_link_err_flag & ~link_err_flag;
    irq_evt[`LSF_IRQ_STN_DROP] = |(stn_ok & ~next_stn_ok);
    irq_clr = 3'h0;
    if (wr_irq_stat) begin
      irq_clr = reg_wdata[2:0];
    end
    // A new event beats a clear in the same cycle
    next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;
    next_irq_mask = irq_mask;
    next_ctrl     = ctrl;
    if (wr_irq_mask) begin
      next_irq_mask = reg_wdata[2:0];
    end
    if (wr_ctrl) begin
      next_ctrl = reg_wdata[1:0];
    end
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // The output is registered, so it cannot glitch while status and mask move
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat <= `LSF_RST_IRQ;
      irq_mask <= `LSF_RST_IRQ;
      ctrl     <= `LSF_RST_CTRL;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      ctrl     <= next_ctrl;
      irq      <= next_irq;
    end
  end

  // =======================================================
  // Read port: data stand one cycle after the strobe, else zero
  // Reads have no side effects; a flag is only cleared by hardware or,
  // for interrupt status, by writing a one.
  logic [15:0] next_rdata;

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `LSF_OFS_P2_STATUS:  next_rdata = p2_word;
        `LSF_OFS_LINK_ERR:   next_rdata = link_word;
        `LSF_OFS_STATION_OK: next_rdata = stn_ok;
        `LSF_OFS_P2_ERRCODE: next_rdata = p2_err_code;
        `LSF_OFS_IRQ_STATUS: next_rdata = {13'h0000, irq_stat};
        `LSF_OFS_IRQ_MASK:   next_rdata = {13'h0000, irq_mask};
        `LSF_OFS_CTRL:       next_rdata = {14'h0000, ctrl};
        default:             next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// ### tb/lsf_chk.sv
// Checker of the flag bank register port and port two flags.
// Assumes it is bound to lsf_link_status_flags.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_defines.svh"
module lsf_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // Port two and interrupt
  input wire logic        p2_instr_start,
  input wire logic        p2_instr_done,
  input wire logic        p2_comm_error,
  input wire logic [15:0] p2_error_code,
  input wire logic        irq
);
  logic        busy, errf, mset, p2r;
  logic        next_busy, next_errf, next_mset;
  logic [15:0] code, next_code;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ====
  // Shadow of port two, kept apart from the design's own state
  always_comb begin
    next_busy = busy ? !p2_instr_done : p2_instr_start;
    next_errf = (busy && p2_comm_error)
                || (errf && (busy || !p2_instr_start));
    next_code = (busy && p2_comm_error) ? p2_error_code : code;
    next_mset = mset || (reg_wr && reg_addr == `LSF_OFS_IRQ_MASK
                         && reg_wdata[2:0] != 3'h0);
  end
  always_ff @(posedge clk) begin
    if (srst) {busy, errf, mset, code} <= '0;
    else {busy, errf, mset, code} <=
      {next_busy, next_errf, next_mset, next_code};
  end
  assign p2r = reg_rd && reg_addr == `LSF_OFS_P2_STATUS;
  // ====
  // Properties
  chk_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  chk_unmap_rd: assert property (reg_rd && reg_addr > `LSF_OFS_CTRL
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_link_unused: assert property (reg_rd && reg_addr == `LSF_OFS_LINK_ERR
    |=> reg_rdata[15:1] == 15'h0000) else $error("link word unused bits set");
  chk_p2_unused: assert property (p2r |=> reg_rdata[15:12] == 4'h0)
    else $error("port two unused bits set");
  chk_ready_bit: assert property (p2r
    |=> reg_rdata[`LSF_P2_READY_BIT] == !$past(busy))
    else $error("ready flag wrong for transfer state");
  chk_error_bit: assert property (p2r
    |=> reg_rdata[`LSF_P2_ERROR_BIT] == $past(errf))
    else $error("port two error flag wrong");
  chk_code_reg: assert property (
    reg_rd && reg_addr == `LSF_OFS_P2_ERRCODE
    |=> reg_rdata == $past(code)) else $error("error code not kept");
  chk_irq_masked: assert property (!mset |-> !irq)
    else $error("interrupt with mask never set");
endmodule
bind lsf_link_status_flags lsf_chk i_lsf_chk (.clk, .srst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .p2_instr_start, .p2_instr_done,
  .p2_comm_error, .p2_error_code, .irq);
`default_nettype wire

// ### tb/lsf_peer.sv
// Model of the other stations on the shared link.
// Assumes the bench sets its masks off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module lsf_peer (
  // Controls from the bench
  input  wire logic [15:0] stop,
  input  wire logic [15:0] fault,
  input  wire logic [15:0] off_link,
  input  wire logic        tx_bad,
  // Station levels towards the flag bank
  output wire logic [15:0] running,
  output wire logic [15:0] error,
  output wire logic [15:0] link_mode,
  output wire logic [15:0] comm_ok,
  output wire logic        tx_error
);
  // A faulty station keeps running but no longer answers properly
  assign running   = ~stop;
  assign error     = fault;
  assign link_mode = ~off_link;
  assign comm_ok   = ~fault;
  assign tx_error  = tx_bad;
endmodule
`default_nettype wire

// ### tb/lsf_link_status_flags_test.sv
// Bench of the flag bank: registers, port two, link and stations.
// Assumes lsf_chk is bound and lsf_peer stands for the other stations.
`timescale 1ns/1ps
`default_nettype none
module lsf_link_status_flags_test;
  logic        clk, srst, reg_wr, reg_rd, cfg_bad, tx_bad, irq, tx_error;
  logic [2:0]  p2ev;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, code, stop, fault, off_link;
  logic [15:0] running, error, link_mode, comm_ok;
  int          fails = 0;
  int          n_tests = 0;
  lsf_link_status_flags i_lsf_link_status_flags (.clk, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .p2_instr_start(p2ev[0]),
    .p2_instr_done(p2ev[1]), .p2_comm_error(p2ev[2]), .p2_error_code(code),
    .link_tx_error(tx_error), .link_area_cfg_error(cfg_bad),
    .station_running(running), .station_error(error),
    .station_link_mode(link_mode), .station_comm_ok(comm_ok), .irq);
  lsf_peer i_lsf_peer (.stop, .fault, .off_link, .tx_bad, .running, .error,
    .link_mode, .comm_ok, .tx_error);
  // ====
  // Bus and compare helpers
  task automatic chk(input string nm, input logic [15:0] s, e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, e);
  endtask
  task automatic p2(input logic [2:0] e);
    @(posedge clk);
    p2ev <= e;
    @(posedge clk);
    p2ev <= 3'h0;
  endtask
  // A fixed wait covers one full scan period plus the update cycle
  task automatic wt;
    repeat (260) @(posedge clk);
  endtask
  // ====
  // Scenarios
  task automatic t_regs;
    logic [15:0] ex [8];
    ex = '{16'h0400, 16'h0000, 16'h0000, 16'h0000,
           16'h0000, 16'h0000, 16'h0003, 16'h0000};
    for (int i = 0; i < 4; i++) wr(8'(i * 4), 16'hffff);
    wr(8'h1c, 16'hffff);
    for (int i = 0; i < 8; i++)
      rc($sformatf("reg %0d", i), 8'(i * 4), ex[i]);
    $display("register test done");
  endtask
  task automatic t_p2;
    code <= 16'h5a3c;
    p2(3'b100);
    rc("idle err", 8'h00, 16'h0400);
    p2(3'b001);
    rc("busy", 8'h00, 16'h0000);
    p2(3'b100);
    rc("err", 8'h00, 16'h0800);
    rc("code", 8'h0c, 16'h5a3c);
    chk("irq masked", {15'h0, irq}, 16'h0000);
    wr(8'h14, 16'h0001);
    rc("irq stat", 8'h10, 16'h0001);
    chk("irq", {15'h0, irq}, 16'h0001);
    p2(3'b010);
    rc("done", 8'h00, 16'h0c00);
    wr(8'h10, 16'h0001);
    code <= 16'h00a5;
    p2(3'b001);
    rc("restart", 8'h00, 16'h0000);
    chk("irq clear", {15'h0, irq}, 16'h0000);
    p2(3'b110);
    rc("err at done", 8'h00, 16'h0c00);
    rc("new code", 8'h0c, 16'h00a5);
    wr(8'h14, 16'h0000);
    $display("port two test done");
  endtask
  task automatic t_link;
    tx_bad <= 1'b1;
    p2(3'b000);
    tx_bad <= 1'b0;
    wt;
    rc("tx err", 8'h04, 16'h0001);
    wt;
    rc("tx gone", 8'h04, 16'h0000);
    cfg_bad <= 1'b1;
    wt;
    rc("area err", 8'h04, 16'h0001);
    cfg_bad <= 1'b0;
    $display("link test done");
  endtask
  task automatic t_stn;
    rc("all ok", 8'h08, 16'hffff);
    stop     <= 16'h0004;
    fault    <= 16'h0010;
    off_link <= 16'h8000;
    wt;
    rc("some down", 8'h08, 16'h7feb);
    {stop, fault, off_link} <= '0;
    rc("irq all", 8'h10, 16'h0007);
    wr(8'h10, 16'h0007);
    rc("irq none", 8'h10, 16'h0000);
    wr(8'h18, 16'h0002);
    tx_bad <= 1'b1;
    wt;
    tx_bad <= 1'b0;
    rc("link off", 8'h08, 16'h0000);
    rc("tx ignored", 8'h04, 16'h0000);
    wr(8'h18, 16'h0003);
    wt;
    rc("back", 8'h08, 16'hffff);
    wr(8'h18, 16'h0001);
    fault <= 16'h0001;
    wt;
    rc("frozen", 8'h08, 16'hffff);
    fault <= 16'h0000;
    wr(8'h18, 16'h0003);
    $display("station test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end
  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, cfg_bad, tx_bad, p2ev, reg_addr} = '0;
    {reg_wdata, code, stop, fault, off_link} = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_p2;
    t_link;
    t_stn;
    tally_and_finish;
  end
endmodule
`default_nettype wire
